//--- rtl/mds_pkg.sv
// Constants, register map and types for the motor start sequencer
package mds_pkg;
   localparam int CLK_PERIOD_NS = 5;
   localparam int TICK_PERIOD_NS = 1000000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int MS_PER_TENTH_S = 100;
   localparam int MS_PER_HUNDREDTH_S = 10;

   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_START_FREQ = 8'h04;
   localparam logic [7:0] ADR_HOLD_TIME = 8'h08;
   localparam logic [7:0] ADR_BRAKE_CUR = 8'h0c;
   localparam logic [7:0] ADR_BRAKE_TIME = 8'h10;
   localparam logic [7:0] ADR_ACC_START = 8'h14;
   localparam logic [7:0] ADR_ACC_END = 8'h18;
   localparam logic [7:0] ADR_DEC_START = 8'h1c;
   localparam logic [7:0] ADR_DEC_END = 8'h20;
   localparam logic [7:0] ADR_TARGET = 8'h24;
   localparam logic [7:0] ADR_RATE = 8'h28;
   localparam logic [7:0] ADR_STATUS = 8'h2c;
   localparam logic [7:0] ADR_OUT_FREQ = 8'h30;

   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_SHAPE_BIT = 2;
   localparam int CTRL_RUN_BIT = 3;

   localparam logic [1:0] MODE_DIRECT = 2'h0;
   localparam logic [1:0] MODE_BRAKE = 2'h1;
   localparam logic [1:0] MODE_TRACK = 2'h2;

   localparam logic [15:0] START_FREQ_RST = 16'h0032;
   localparam logic [15:0] START_FREQ_MAX = 16'h1388;
   localparam logic [15:0] HOLD_TIME_RST = 16'h0000;
   localparam logic [15:0] HOLD_TIME_MAX = 16'h01f4;
   localparam logic [15:0] BRAKE_CUR_RST = 16'h0000;
   localparam logic [15:0] BRAKE_CUR_MAX = 16'h03e8;
   localparam logic [15:0] BRAKE_TIME_RST = 16'h0000;
   localparam logic [15:0] BRAKE_TIME_MAX = 16'h1388;
   localparam logic [15:0] SEG_TIME_RST = 16'h0001;
   localparam logic [15:0] SEG_TIME_MAX = 16'h01f4;
   localparam logic [15:0] TARGET_RST = 16'h0000;
   localparam logic [15:0] RATE_RST = 16'h0001;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_STANDBY,
      ST_BRAKE,
      ST_HOLD,
      ST_RUN
   } mds_state_type;

   typedef struct packed {
      logic [15:0] acc_start;
      logic [15:0] acc_end;
      logic [15:0] dec_start;
      logic [15:0] dec_end;
   } mds_seg_type;
endpackage

//--- rtl/mds_ramp.sv
// Frequency ramp generator with linear and S-curve shapes
`timescale 1ns/10ps
`default_nettype none
module mds_ramp
   import mds_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic tick,
   input wire logic enable,
   input wire logic load,
   input wire logic [15:0] load_val,
   input wire logic [15:0] target,
   input wire logic [15:0] rate,
   input wire logic s_mode,
   input wire mds_seg_type seg,
   output logic [15:0] freq
);
   logic [15:0] freq_q;
   logic [15:0] freq_d;
   logic [15:0] step_q;
   logic [15:0] step_d;
   logic [23:0] acc_q;
   logic [23:0] acc_d;

   wire up = target > freq_q;
   wire [15:0] diff = up ? target - freq_q : freq_q - target;
   wire [15:0] seg_s = up ? seg.acc_start : seg.dec_start;
   wire [15:0] seg_e = up ? seg.acc_end : seg.dec_end;
   wire [23:0] seg_s_ms = 24'(seg_s * 16'(MS_PER_TENTH_S));
   wire [23:0] seg_e_ms = 24'(seg_e * 16'(MS_PER_TENTH_S));
   wire [39:0] stop_dist = step_q * seg_e_ms;
   wire need_end = {23'h0, diff, 1'b0} <= stop_dist;
   wire [15:0] s_step = (step_q == 16'h0) ? 16'h1 : step_q;
   wire [15:0] raw_step = s_mode ? s_step : rate;
   wire [15:0] delta = (raw_step > diff) ? diff : raw_step;
   wire [23:0] acc_sum = acc_q + {8'h0, rate};
   wire [23:0] seg_use = need_end ? seg_e_ms : seg_s_ms;
   wire acc_wrap = acc_sum >= seg_use;

   assign freq = freq_q;

   always_comb
   begin
      freq_d = freq_q;
      step_d = step_q;
      acc_d = acc_q;
      if (load)
      begin
         freq_d = load_val;
         step_d = 16'h0;
         acc_d = 24'h0;
      end
      else if (enable && tick)
      begin
         if (diff == 16'h0)
         begin
            step_d = 16'h0;
            acc_d = 24'h0;
         end
         else
         begin
            freq_d = up ? freq_q + delta : freq_q - delta;
            // S curve: slope grows over start segment, shrinks over end
            if (s_mode && seg_use == 24'h0)
               step_d = need_end ? 16'h1 : rate;
            else if (s_mode && acc_wrap)
            begin
               acc_d = acc_sum - seg_use;
               if (need_end && step_q > 16'h1)
                  step_d = step_q - 16'h1;
               else if (!need_end && step_q < rate)
                  step_d = step_q + 16'h1;
            end
            else if (s_mode)
               acc_d = acc_sum;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         freq_q <= 16'h0;
         step_q <= 16'h0;
         acc_q <= 24'h0;
      end
      else
      begin
         freq_q <= freq_d;
         step_q <= step_d;
         acc_q <= acc_d;
      end
   end
endmodule
`default_nettype wire

//--- rtl/mds_top.sv
// Motor drive start sequencer with Wishbone register access
//
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module mds_top
   import mds_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
)
(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic [15:0] ROTOR_FREQ_EST,
   output logic [15:0] FREQ_REF,
   output logic BRAKE_EN,
   output logic [15:0] BRAKE_CURRENT,
   output logic RUNNING,
   output logic STANDBY
);
   function automatic logic [15:0] wr16(input logic [15:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] sel,
                                        input logic [15:0] max);
      logic [15:0] v;
      v = old;
      if (sel[0])
         v[7:0] = dat[7:0];
      if (sel[1])
         v[15:8] = dat[15:8];
      wr16 = (v > max) ? max : v;
   endfunction

   logic ack_q;
   logic [31:0] dat_q;
   logic [1:0] mode_q;
   logic shape_q;
   logic run_q;
   logic [15:0] start_freq_q;
   logic [15:0] hold_q;
   logic [15:0] brake_cur_q;
   logic [15:0] brake_time_q;
   mds_seg_type seg_q;
   logic [15:0] target_q;
   logic [15:0] rate_q;
   logic [31:0] pre_q;
   logic tick_q;
   logic [23:0] tmr_q;
   logic [23:0] tmr_d;
   mds_state_type st_q;
   mds_state_type st_d;
   logic ramp_load;
   logic [15:0] ramp_val;
   logic [15:0] ramp_freq;
   logic [15:0] brake_out_q;
   logic brake_en_q;
   logic [15:0] freq_out_q;

   // Bus decode
   wire req = WB_CYC_I && WB_STB_I && !ack_q;
   wire wr = req && WB_WE_I;
   wire [3:0] sel = WB_SEL_I;
   wire [23:0] hold_ms_w = 24'(hold_q * 16'(MS_PER_TENTH_S));
   wire [23:0] brake_ms = 24'(brake_time_q * 16'(MS_PER_HUNDREDTH_S));
   wire below_start = target_q < start_freq_q;
   wire [31:0] rd_ctrl = {28'h0, run_q, shape_q, mode_q};
   wire [31:0] rd_status = {25'h0, STANDBY, RUNNING, BRAKE_EN, 1'b0,
                            3'(st_q)};
   wire [31:0] rd_mux =
      (WB_ADR_I == ADR_CTRL) ? rd_ctrl :
      (WB_ADR_I == ADR_START_FREQ) ? {16'h0, start_freq_q} :
      (WB_ADR_I == ADR_HOLD_TIME) ? {16'h0, hold_q} :
      (WB_ADR_I == ADR_BRAKE_CUR) ? {16'h0, brake_cur_q} :
      (WB_ADR_I == ADR_BRAKE_TIME) ? {16'h0, brake_time_q} :
      (WB_ADR_I == ADR_ACC_START) ? {16'h0, seg_q.acc_start} :
      (WB_ADR_I == ADR_ACC_END) ? {16'h0, seg_q.acc_end} :
      (WB_ADR_I == ADR_DEC_START) ? {16'h0, seg_q.dec_start} :
      (WB_ADR_I == ADR_DEC_END) ? {16'h0, seg_q.dec_end} :
      (WB_ADR_I == ADR_TARGET) ? {16'h0, target_q} :
      (WB_ADR_I == ADR_RATE) ? {16'h0, rate_q} :
      (WB_ADR_I == ADR_STATUS) ? rd_status :
      (WB_ADR_I == ADR_OUT_FREQ) ? {16'h0, freq_out_q} : 32'h0;

   assign WB_ACK_O = ack_q;
   assign WB_DAT_O = dat_q;
   assign FREQ_REF = freq_out_q;
   assign BRAKE_EN = brake_en_q;
   assign BRAKE_CURRENT = brake_out_q;
   assign RUNNING = (st_q == ST_HOLD) || (st_q == ST_RUN);
   assign STANDBY = (st_q == ST_STANDBY);

   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         ack_q <= 1'b0;
         dat_q <= 32'h0;
      end
      else
      begin
         ack_q <= req;
         dat_q <= (req && !WB_WE_I) ? rd_mux : 32'h0;
      end
   end

   // Register writes, ranges clamped on write
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         mode_q <= MODE_DIRECT;
         shape_q <= 1'b0;
         run_q <= 1'b0;
         start_freq_q <= START_FREQ_RST;
         hold_q <= HOLD_TIME_RST;
         brake_cur_q <= BRAKE_CUR_RST;
         brake_time_q <= BRAKE_TIME_RST;
         seg_q <= {4{SEG_TIME_RST}};
         target_q <= TARGET_RST;
         rate_q <= RATE_RST;
      end
      else if (wr)
      begin
         if (WB_ADR_I == ADR_CTRL && sel[0])
         begin
            mode_q <= (WB_DAT_I[1:0] == 2'h3) ? MODE_TRACK : WB_DAT_I[1:0];
            shape_q <= WB_DAT_I[CTRL_SHAPE_BIT];
            run_q <= WB_DAT_I[CTRL_RUN_BIT];
         end
         if (WB_ADR_I == ADR_START_FREQ)
            start_freq_q <= wr16(start_freq_q, WB_DAT_I, sel, START_FREQ_MAX);
         if (WB_ADR_I == ADR_HOLD_TIME)
            hold_q <= wr16(hold_q, WB_DAT_I, sel, HOLD_TIME_MAX);
         if (WB_ADR_I == ADR_BRAKE_CUR)
            brake_cur_q <= wr16(brake_cur_q, WB_DAT_I, sel, BRAKE_CUR_MAX);
         if (WB_ADR_I == ADR_BRAKE_TIME)
            brake_time_q <= wr16(brake_time_q, WB_DAT_I, sel, BRAKE_TIME_MAX);
         if (WB_ADR_I == ADR_ACC_START)
            seg_q.acc_start <= wr16(seg_q.acc_start, WB_DAT_I, sel,
                                    SEG_TIME_MAX);
         if (WB_ADR_I == ADR_ACC_END)
            seg_q.acc_end <= wr16(seg_q.acc_end, WB_DAT_I, sel, SEG_TIME_MAX);
         if (WB_ADR_I == ADR_DEC_START)
            seg_q.dec_start <= wr16(seg_q.dec_start, WB_DAT_I, sel,
                                    SEG_TIME_MAX);
         if (WB_ADR_I == ADR_DEC_END)
            seg_q.dec_end <= wr16(seg_q.dec_end, WB_DAT_I, sel, SEG_TIME_MAX);
         if (WB_ADR_I == ADR_TARGET)
            target_q <= wr16(target_q, WB_DAT_I, sel, 16'hffff);
         if (WB_ADR_I == ADR_RATE)
            rate_q <= wr16(rate_q, WB_DAT_I, sel, 16'hffff);
      end
   end

   // Millisecond time base
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         pre_q <= 32'h0;
         tick_q <= 1'b0;
      end
      else
      begin
         tick_q <= (pre_q == 32'(TICK_CYC - 1));
         pre_q <= (pre_q == 32'(TICK_CYC - 1)) ? 32'h0 : pre_q + 32'h1;
      end
   end

   // Start sequence
   always_comb
   begin
      st_d = st_q;
      tmr_d = (tick_q && tmr_q != 24'h0) ? tmr_q - 24'h1 : tmr_q;
      ramp_load = 1'b0;
      ramp_val = 16'h0;
      case (st_q)
         ST_IDLE, ST_STANDBY:
         begin
            ramp_load = 1'b1;
            if (!run_q)
               st_d = ST_IDLE;
            else if (below_start)
               st_d = ST_STANDBY;
            else if (mode_q == MODE_TRACK)
            begin
               ramp_val = ROTOR_FREQ_EST;
               st_d = ST_RUN;
            end
            else if (mode_q == MODE_BRAKE && brake_ms != 24'h0)
            begin
               tmr_d = brake_ms;
               st_d = ST_BRAKE;
            end
            else
            begin
               ramp_val = start_freq_q;
               tmr_d = hold_ms_w;
               st_d = ST_HOLD;
            end
         end
         ST_BRAKE:
         begin
            ramp_load = 1'b1;
            ramp_val = start_freq_q;
            if (!run_q)
               st_d = ST_IDLE;
            else if (tmr_q == 24'h0)
            begin
               tmr_d = hold_ms_w;
               st_d = ST_HOLD;
            end
         end
         ST_HOLD:
         begin
            ramp_load = 1'b1;
            ramp_val = start_freq_q;
            if (!run_q)
               st_d = ST_IDLE;
            else if (tmr_q == 24'h0)
               st_d = ST_RUN;
         end
         ST_RUN:
         begin
            if (!run_q)
               st_d = ST_IDLE;
         end
         default:
            st_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         st_q <= ST_IDLE;
         tmr_q <= 24'h0;
         brake_en_q <= 1'b0;
         brake_out_q <= 16'h0;
         freq_out_q <= 16'h0;
      end
      else
      begin
         st_q <= st_d;
         tmr_q <= tmr_d;
         brake_en_q <= (st_d == ST_BRAKE);
         brake_out_q <= (st_d == ST_BRAKE) ? brake_cur_q : 16'h0;
         freq_out_q <= (st_q == ST_BRAKE || !RUNNING) ? 16'h0 : ramp_freq;
      end
   end

   mds_ramp u_ramp (
      .clk(CLK),
      .rstn(RSTN),
      .tick(tick_q),
      .enable(st_q == ST_RUN),
      .load(ramp_load),
      .load_val(ramp_val),
      .target(target_q),
      .rate(rate_q),
      .s_mode(shape_q),
      .seg(seg_q),
      .freq(ramp_freq)
   );
endmodule
`default_nettype wire

//--- tb/mds_motor_model.sv
// Power stage and motor model that feeds back a rotor speed estimate
`timescale 1ns/10ps
`default_nettype none
module mds_motor_model
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [15:0] freq_ref,
   input wire logic brake_en,
   input wire logic preset_en,
   input wire logic [15:0] preset_val,
   output logic [15:0] rotor_est
);
   // Rotor follows the drive, stops under braking, coasts otherwise
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rotor_est <= 16'h0000;
      else if (preset_en)
         rotor_est <= preset_val;
      else if (brake_en)
         rotor_est <= 16'h0000;
      else if (freq_ref != 16'h0000)
         rotor_est <= freq_ref;
   end
endmodule
`default_nettype wire

//--- tb/mds_top_assertions.sv
// Port checks for the start sequencer
`timescale 1ns/10ps
`default_nettype none
module mds_top_assertions
   import mds_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
)
(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   input wire logic [15:0] ROTOR_FREQ_EST,
   input wire logic [15:0] FREQ_REF,
   input wire logic BRAKE_EN,
   input wire logic [15:0] BRAKE_CURRENT,
   input wire logic RUNNING,
   input wire logic STANDBY
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RSTN);
   property p_ack;
      WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
   endproperty
   a_ack: assert property (p_ack) else $error("ack missing");
   property p_ack_one;
      WB_ACK_O |=> !WB_ACK_O;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack too long");
   property p_dat_idle;
      !WB_ACK_O |-> WB_DAT_O == 32'h00000000;
   endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("data not zero");
   property p_brake_start;
      $rose(BRAKE_EN) |-> FREQ_REF == 16'h0000 && !RUNNING;
   endproperty
   a_brake_start: assert property (p_brake_start)
      else $error("brake bad");
   property p_standby_excl;
      STANDBY |-> !RUNNING && !BRAKE_EN;
   endproperty
   a_standby_excl: assert property (p_standby_excl)
      else $error("sby");
   property p_standby_freq;
      STANDBY && $past(STANDBY) |-> FREQ_REF == 16'h0000;
   endproperty
   a_standby_freq: assert property (p_standby_freq)
      else $error("sby f");
   property p_off_zero;
      !RUNNING && !$past(RUNNING) |-> FREQ_REF == 16'h0000;
   endproperty
   a_off_zero: assert property (p_off_zero)
      else $error("freq when off");
   property p_cur_zero;
      !BRAKE_EN && !$past(BRAKE_EN) |-> BRAKE_CURRENT == 16'h0000;
   endproperty
   a_cur_zero: assert property (p_cur_zero)
      else $error("brake cur");
endmodule
bind mds_top mds_top_assertions #(.TICK_CYC(TICK_CYC)) u_chk (.CLK(CLK),
   .RSTN(RSTN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
   .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
   .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .ROTOR_FREQ_EST(ROTOR_FREQ_EST),
   .FREQ_REF(FREQ_REF), .BRAKE_EN(BRAKE_EN), .BRAKE_CURRENT(BRAKE_CURRENT),
   .RUNNING(RUNNING), .STANDBY(STANDBY));
`default_nettype wire

//--- tb/tb_top.sv
// Register-level testbench for the start sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import mds_pkg::*;
;
   localparam int TC = 20;
   logic clk, rstn, cyc, stb, we, ack, brk, run, sby, pre_en;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, r;
   logic [15:0] rotor, fref, bcur, pre_val, f0;
   int err_total, checks;
   mds_top #(.TICK_CYC(TC)) dut (.CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
      .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .ROTOR_FREQ_EST(rotor), .FREQ_REF(fref), .BRAKE_EN(brk),
      .BRAKE_CURRENT(bcur), .RUNNING(run), .STANDBY(sby));
   mds_motor_model mot (.clk(clk), .rstn(rstn), .freq_ref(fref),
      .brake_en(brk), .preset_en(pre_en), .preset_val(pre_val),
      .rotor_est(rotor));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic wrap_up();
      if (err_total == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s,
                      input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      do @(posedge clk); while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rc(input string n, input logic [7:0] a,
                     input logic [31:0] e);
      wb(1'b0, a, 32'h00000000);
      chk(n, r, e);
   endtask
   task automatic cy(input int n);
      repeat (n) @(negedge clk);
   endtask
   initial
   begin
      #400000;
      err_total++;
      wrap_up();
   end
   initial
   begin
      {rstn, cyc, stb, we, pre_en} = 5'h00;
      {adr, sel, wdat, pre_val} = 60'h0;
      err_total = 0;
      checks = 0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      rc("ctrl", ADR_CTRL, 32'h00000000);
      rc("sfreq", ADR_START_FREQ, 32'h00000032);
      rc("hold", ADR_HOLD_TIME, 32'h00000000);
      rc("bcur", ADR_BRAKE_CUR, 32'h00000000);
      rc("btime", ADR_BRAKE_TIME, 32'h00000000);
      rc("seg", ADR_ACC_START, 32'h00000001);
      rc("unmapped", 8'h3c, 32'h00000000);
      wr(ADR_START_FREQ, 32'h0000ffff);
      rc("sfmax", ADR_START_FREQ, 32'h00001388);
      wr(ADR_CTRL, 32'h00000003);
      rc("mode3", ADR_CTRL, 32'h00000002);
      // Target below start frequency waits in standby
      wr(ADR_START_FREQ, 32'h00000064);
      wr(ADR_TARGET, 32'h00000032);
      wr(ADR_CTRL, 32'h00000008);
      cy(3);
      chk("sby", {sby, run}, 32'h2);
      rc("stat", ADR_STATUS, 32'h00000041);
      wr(ADR_TARGET, 32'h000003e8);
      cy(3);
      chk("sby run", {sby, run}, 32'h1);
      wr(ADR_CTRL, 32'h00000000);
      // Low start frequency held, then linear ramp
      wr(ADR_START_FREQ, 32'h00000005);
      wr(ADR_HOLD_TIME, 32'h00000001);
      wr(ADR_RATE, 32'h00000005);
      wr(ADR_CTRL, 32'h00000008);
      cy(3);
      chk("hold f", fref, 32'h5);
      repeat (90) cy(TC);
      chk("hold end", fref, 32'h5);
      rc("hstat", ADR_STATUS, 32'h00000023);
      repeat (20) cy(TC);
      f0 = fref;
      repeat (10) cy(TC);
      chk("linear", fref - f0, 32'h32);
      wr(ADR_CTRL, 32'h00000000);
      // S curve with segment times programmed
      wr(ADR_ACC_START, 32'h00000001);
      wr(ADR_ACC_END, 32'h00000001);
      wr(ADR_DEC_START, 32'h00000001);
      wr(ADR_DEC_END, 32'h00000001);
      wr(ADR_HOLD_TIME, 32'h00000000);
      wr(ADR_CTRL, 32'h0000000c);
      cy(3);
      f0 = fref;
      repeat (10) cy(TC);
      chk("s curve", (fref > f0) && (fref - f0 < 16'h0014), 32'h1);
      wr(ADR_CTRL, 32'h00000000);
      // Braking before start, then with zero time
      wr(ADR_BRAKE_CUR, 32'h000001f4);
      wr(ADR_BRAKE_TIME, 32'h00000002);
      wr(ADR_CTRL, 32'h00000009);
      cy(3);
      chk("brake", {brk, run}, 32'h2);
      chk("brake cur", bcur, 32'h1f4);
      chk("brake f", fref, 32'h0);
      repeat (15) cy(TC);
      chk("brake on", brk, 32'h1);
      repeat (10) cy(TC);
      chk("brake off", {brk, run}, 32'h1);
      wr(ADR_CTRL, 32'h00000000);
      wr(ADR_BRAKE_TIME, 32'h00000000);
      wr(ADR_CTRL, 32'h00000009);
      cy(3);
      chk("no brake", {brk, run}, 32'h1);
      wr(ADR_CTRL, 32'h00000000);
      // Tracking start picks up the spinning rotor
      @(posedge clk);
      pre_en <= 1'b1;
      pre_val <= 16'h01f4;
      @(posedge clk);
      pre_en <= 1'b0;
      wr(ADR_CTRL, 32'h0000000a);
      cy(3);
      chk("track", fref >= 16'h01f4 && fref <= 16'h01f9, 32'h1);
      chk("track run", run, 32'h1);
      wrap_up();
   end
endmodule
`default_nettype wire
